// file: verilog/tcc_pkg.sv
// package: register map, field positions and mode codes for compare channels 5 and 6
package tcc_pkg;
  localparam logic [7:0] CH56_MODE_OFFSET = 8'h54;
  localparam logic [7:0] CH5_VALUE_OFFSET = 8'h58;
  localparam logic [7:0] CH6_VALUE_OFFSET = 8'h5c;
  localparam logic [7:0] CTRL_OFFSET = 8'h60;
  localparam logic [7:0] STATUS_OFFSET = 8'h64;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WRITE_MASK = 16'hfcfc;
  localparam int CH5_FAST_BIT = 2;
  localparam int CH5_PRELOAD_BIT = 3;
  localparam int CH5_MODE_LSB = 4;
  localparam int CH5_CLEAR_BIT = 7;
  localparam int CH6_FAST_BIT = 10;
  localparam int CH6_PRELOAD_BIT = 11;
  localparam int CH6_MODE_LSB = 12;
  localparam int CH6_CLEAR_BIT = 15;
  localparam int CTRL_UPDATE_DISABLE_BIT = 0;
  localparam int CTRL_SW_UPDATE_BIT = 1;
  localparam logic [2:0] MODE_FROZEN = 3'h0;
  localparam logic [2:0] MODE_SET_ON_MATCH = 3'h1;
  localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_FORCE_LOW = 3'h4;
  localparam logic [2:0] MODE_FORCE_HIGH = 3'h5;
  localparam logic [2:0] MODE_PWM1 = 3'h6;
  localparam logic [2:0] MODE_PWM2 = 3'h7;
endpackage

// file: verilog/tcc_channel.sv
// module: one output-only compare channel with preload and active value
`timescale 1ns/10ps
`default_nettype none
module tcc_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_value,
  input wire logic [15:0] wr_data,
  input wire logic preload_en,
  input wire logic [2:0] out_mode,
  input wire logic clear_en,
  input wire logic clear_in,
  input wire logic update_event,
  input wire logic [15:0] counter,
  output logic [15:0] preload_value,
  output logic [15:0] active_value,
  output logic compare_out
);
  typedef struct packed {
    logic [15:0] pre;
    logic [15:0] act;
    logic out;
  } tcc_ch_state_type;

  tcc_ch_state_type st_reg;
  tcc_ch_state_type st_next;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (wr_value) begin
      st_next.pre = wr_data;
      if (!preload_en) begin
        st_next.act = wr_data; // immediate transfer
      end
    end
    // a write in the same cycle as an update cancels the update; the active value is kept
    if (update_event && preload_en && !wr_value) begin
      st_next.act = st_reg.pre; // held until update
    end
    // compare against the counter
    case (out_mode)
      tcc_pkg::MODE_FROZEN: st_next.out = st_reg.out;
      tcc_pkg::MODE_SET_ON_MATCH: st_next.out = (counter == st_reg.act) ? 1'b1 : st_reg.out;
      tcc_pkg::MODE_CLEAR_ON_MATCH: st_next.out = (counter == st_reg.act) ? 1'b0 : st_reg.out;
      tcc_pkg::MODE_TOGGLE: st_next.out = (counter == st_reg.act) ? !st_reg.out : st_reg.out;
      tcc_pkg::MODE_FORCE_LOW: st_next.out = 1'b0;
      tcc_pkg::MODE_FORCE_HIGH: st_next.out = 1'b1;
      tcc_pkg::MODE_PWM1: st_next.out = (counter < st_reg.act);
      tcc_pkg::MODE_PWM2: st_next.out = !(counter < st_reg.act);
      default: st_next.out = st_reg.out;
    endcase
    // clear applies in every mode except force-high; a forced-high level stays
    if (clear_en && clear_in && out_mode != tcc_pkg::MODE_FORCE_HIGH) begin
      st_next.out = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign preload_value = st_reg.pre;
  assign active_value = st_reg.act;
  assign compare_out = st_reg.out;
endmodule // tcc_channel
`default_nettype wire

// file: verilog/tcc_top.sv
// module: compare channels 5 and 6 with wishbone register slave
// Function
// - channel 5: 16-bit value, output only
// - channel 6: 16-bit value, output only
// - channel 5 value compared with counter
// - channel 6 value compared with counter
// - channel 5 preload: immediate or on update
// - channel 6 preload: immediate or on update
// - channel 5 output drives comparator blanking
// - channel 6 output drives op-amp switch
// - update on over/underflow or software request
`timescale 1ns/10ps
`default_nettype none
module tcc_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [15:0] TIMER_COUNTER,
  input wire logic COUNTER_OVERFLOW,
  input wire logic COUNTER_UNDERFLOW,
  input wire logic CLEAR_IN,
  output logic UPDATE_EVENT,
  output logic COMP_BLANKING,
  output logic OPAMP_SWITCH
);
  typedef struct packed {
    logic [15:0] mode;
    logic upd_disable;
    logic sw_req;
    logic ack;
    logic [31:0] rdata;
  } tcc_state_type;

  tcc_state_type st_reg;
  tcc_state_type st_next;
  logic [15:0] ch5_pre;
  logic [15:0] ch5_act;
  logic [15:0] ch6_pre;
  logic [15:0] ch6_act;
  logic ch5_out;
  logic ch6_out;
  logic bus_req;
  logic wr5;
  logic wr6;
  logic update_event;
  logic bus_wr;
  logic bus_rd;
  logic low_lanes;
  logic mode_wr;
  logic ctrl_wr;
  logic [15:0] ch5_wr_data;
  logic [15:0] ch6_wr_data;
  logic ch5_preload_enable;
  logic ch6_preload_enable;
  logic [2:0] ch5_output_mode;
  logic [2:0] ch6_output_mode;
  logic ch5_clear_enable;
  logic ch6_clear_enable;

  // merge a write with byte lanes into a 16-bit register
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0] sel
  );
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // 16-bit register in the low half of the bus, upper half reads zero
  function automatic logic [31:0] low_half(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  // single-cycle ack; the cycle with ack high masks the request and blocks a double write
  assign bus_req = WB_CYC_I && WB_STB_I && !st_reg.ack;
  assign bus_wr = bus_req && WB_WE_I;
  assign bus_rd = bus_req && !WB_WE_I;
  // compare values live in lanes 0 and 1 only
  assign low_lanes = |WB_SEL_I[1:0];
  assign wr5 = bus_wr && WB_ADR_I == tcc_pkg::CH5_VALUE_OFFSET && low_lanes;
  assign wr6 = bus_wr && WB_ADR_I == tcc_pkg::CH6_VALUE_OFFSET && low_lanes;
  assign mode_wr = bus_wr && WB_ADR_I == tcc_pkg::CH56_MODE_OFFSET;
  assign ctrl_wr = bus_wr && WB_ADR_I == tcc_pkg::CTRL_OFFSET && WB_SEL_I[0];
  // an unselected lane keeps its old byte in the preload value
  assign ch5_wr_data = lane_merge(ch5_pre, WB_DAT_I, WB_SEL_I);
  assign ch6_wr_data = lane_merge(ch6_pre, WB_DAT_I, WB_SEL_I);

  // --------------------------------------------------------------
  // channel configuration
  // --------------------------------------------------------------
  // fast enable bits are stored and read back only
  assign ch5_preload_enable = st_reg.mode[tcc_pkg::CH5_PRELOAD_BIT];
  assign ch6_preload_enable = st_reg.mode[tcc_pkg::CH6_PRELOAD_BIT];
  assign ch5_output_mode = st_reg.mode[tcc_pkg::CH5_MODE_LSB +: 3];
  assign ch6_output_mode = st_reg.mode[tcc_pkg::CH6_MODE_LSB +: 3];
  assign ch5_clear_enable = st_reg.mode[tcc_pkg::CH5_CLEAR_BIT];
  assign ch6_clear_enable = st_reg.mode[tcc_pkg::CH6_CLEAR_BIT];

  // --------------------------------------------------------------
  // update event
  // --------------------------------------------------------------
  assign update_event = COUNTER_OVERFLOW || COUNTER_UNDERFLOW
                        || (st_reg.sw_req && !st_reg.upd_disable);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // ack answers the taking edge and drops one cycle later
    st_next.ack = bus_req;
    // software request is a one-cycle pulse, never read back
    st_next.sw_req = 1'b0;
    st_next.rdata = 32'h0000_0000;
    // reserved mode bits are masked so they always read zero
    if (mode_wr) begin
      st_next.mode = lane_merge(st_reg.mode, WB_DAT_I, WB_SEL_I) & tcc_pkg::MODE_WRITE_MASK;
    end
    if (ctrl_wr) begin
      st_next.upd_disable = WB_DAT_I[tcc_pkg::CTRL_UPDATE_DISABLE_BIT];
      st_next.sw_req = WB_DAT_I[tcc_pkg::CTRL_SW_UPDATE_BIT];
    end
    if (bus_rd) begin
      case (WB_ADR_I)
        tcc_pkg::CH56_MODE_OFFSET: begin
          st_next.rdata = low_half(st_reg.mode);
        end
        tcc_pkg::CH5_VALUE_OFFSET: begin
          st_next.rdata = low_half(ch5_pre);
        end
        tcc_pkg::CH6_VALUE_OFFSET: begin
          st_next.rdata = low_half(ch6_pre);
        end
        tcc_pkg::CTRL_OFFSET: begin
          st_next.rdata = {31'h0000_0000, st_reg.upd_disable};
        end
        tcc_pkg::STATUS_OFFSET: begin
          // both active values at once, to see when an update landed
          st_next.rdata = {ch6_act, ch5_act};
        end
        default: begin
          st_next.rdata = 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------
  // channels
  // --------------------------------------------------------------
  tcc_channel u_ch5 (
    .clk(CLK),
    .rst_n(RST_N),
    .wr_value(wr5),
    .wr_data(ch5_wr_data),
    .preload_en(ch5_preload_enable),
    .out_mode(ch5_output_mode),
    .clear_en(ch5_clear_enable),
    .clear_in(CLEAR_IN),
    .update_event(update_event),
    .counter(TIMER_COUNTER),
    .preload_value(ch5_pre),
    .active_value(ch5_act),
    .compare_out(ch5_out)
  );

  tcc_channel u_ch6 (
    .clk(CLK),
    .rst_n(RST_N),
    .wr_value(wr6),
    .wr_data(ch6_wr_data),
    .preload_en(ch6_preload_enable),
    .out_mode(ch6_output_mode),
    .clear_en(ch6_clear_enable),
    .clear_in(CLEAR_IN),
    .update_event(update_event),
    .counter(TIMER_COUNTER),
    .preload_value(ch6_pre),
    .active_value(ch6_act),
    .compare_out(ch6_out)
  );

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign WB_ACK_O = st_reg.ack;
  assign WB_DAT_O = st_reg.rdata;
  assign UPDATE_EVENT = update_event;
  assign COMP_BLANKING = ch5_out;
  assign OPAMP_SWITCH = ch6_out;
endmodule // tcc_top
`default_nettype wire

// file: dv/tcc_monitor.sv
// checker: bus handshake and update-event properties
`timescale 1ns/10ps
`default_nettype none
module tcc_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic COUNTER_OVERFLOW,
  input wire logic COUNTER_UNDERFLOW,
  input wire logic UPDATE_EVENT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic req;
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  a_update_overflow: assert property (COUNTER_OVERFLOW |-> UPDATE_EVENT)
    else $error("no update on overflow");
  a_update_underflow: assert property (COUNTER_UNDERFLOW |-> UPDATE_EVENT)
    else $error("no update on underflow");
  a_sw_update: assert property (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == 8'h60
    && WB_DAT_I[1:0] == 2'h2 |=> UPDATE_EVENT) else $error("software update lost");
  a_update_cause: assert property (UPDATE_EVENT |-> COUNTER_OVERFLOW || COUNTER_UNDERFLOW
    || $past(req && WB_WE_I && WB_ADR_I == 8'h60)) else $error("update without cause");
  a_ack_after_req: assert property (req |=> WB_ACK_O)
    else $error("request not answered");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_no_stray_ack: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");
  a_unmapped_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I > 8'h64
    |-> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
endmodule // tcc_monitor
bind tcc_top tcc_monitor i_tcc_monitor (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .COUNTER_OVERFLOW(COUNTER_OVERFLOW), .COUNTER_UNDERFLOW(COUNTER_UNDERFLOW),
  .UPDATE_EVENT(UPDATE_EVENT));
`default_nettype wire

// file: dv/tcc_load_model.sv
// far-side model: comparator blanking and op-amp switch loads
`timescale 1ns/10ps
`default_nettype none
module tcc_load_model (
  input wire logic CLK,
  input wire logic blank_in,
  input wire logic switch_in,
  output logic blank_seen = 1'b0,
  output logic switch_seen = 1'b0
);
  // loads only sense levels; sticky flags show activity
  always_ff @(posedge CLK) begin
    blank_seen <= blank_seen | blank_in;
    switch_seen <= switch_seen | switch_in;
  end
endmodule // tcc_load_model
`default_nettype wire

// file: dv/tb_top.sv
// testbench: registers, preload and update paths, compare outputs
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, CLEAR_IN, UPDATE_EVENT;
  logic COUNTER_OVERFLOW, COUNTER_UNDERFLOW, COMP_BLANKING, OPAMP_SWITCH, bseen, sseen;
  logic [7:0] WB_ADR_I;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, q, rnd;
  logic [15:0] TIMER_COUNTER, v5, v6, a5, a6;
  int errors, total_checks, cyc;
  tcc_top i_tcc_top (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TIMER_COUNTER(TIMER_COUNTER),
    .COUNTER_OVERFLOW(COUNTER_OVERFLOW), .COUNTER_UNDERFLOW(COUNTER_UNDERFLOW),
    .CLEAR_IN(CLEAR_IN), .UPDATE_EVENT(UPDATE_EVENT), .COMP_BLANKING(COMP_BLANKING),
    .OPAMP_SWITCH(OPAMP_SWITCH));
  tcc_load_model i_tcc_load_model (.CLK(CLK), .blank_in(COMP_BLANKING),
    .switch_in(OPAMP_SWITCH), .blank_seen(bseen), .switch_seen(sseen));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'h3, we, a, 4'h3, d};
    do begin
      @(posedge CLK);
    end while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
    @(posedge CLK);
  endtask
  task automatic cmp_out(input logic [15:0] c);
    TIMER_COUNTER <= c;
    @(posedge CLK);
    @(posedge CLK);
    chk(COMP_BLANKING, c < a5);
    chk(OPAMP_SWITCH, c < a6);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // hang guard, far above the roughly 150 cycles needed
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      stop_test;
    end
  end
  initial begin
    {RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, COUNTER_OVERFLOW, COUNTER_UNDERFLOW} = 6'h0;
    {CLEAR_IN, WB_ADR_I, WB_SEL_I, WB_DAT_I, TIMER_COUNTER} = {13'h3, 48'h0};
    {a5, a6, rnd} = {32'h0, 32'hc9502639};
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    for (int a = 'h54; a <= 'h70; a += 4) begin
      wb(1'b0, 8'(a), 32'h0);
      chk(q, 32'h0);
    end
    rnd = lfsr(rnd);
    wb(1'b1, 8'h54, rnd);
    wb(1'b0, 8'h54, 32'h0);
    chk(q, {16'h0, rnd[15:0] & 16'hfcfc});
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 8'h54, {16'h0, 16'h6860 | {12'h0, k[0], 3'h0}});
      rnd = lfsr(rnd);
      {v5, v6} = rnd;
      wb(1'b1, 8'h58, {16'h0, v5});
      wb(1'b1, 8'h5c, {16'h0, v6});
      if (!k[0])
        a5 = v5;
      wb(1'b0, 8'h64, 32'h0);
      chk(q, {a6, a5});
      case (k)
        0: COUNTER_OVERFLOW <= 1'b1;
        1: COUNTER_UNDERFLOW <= 1'b1;
        default: wb(1'b1, 8'h60, {30'h0, 2'(k)});
      endcase
      @(posedge CLK);
      {COUNTER_OVERFLOW, COUNTER_UNDERFLOW} <= 2'h0;
      if (k < 3)
        {a5, a6} = {v5, v6};
      wb(1'b0, 8'h64, 32'h0);
      chk(q, {a6, a5});
      cmp_out(a5);
      cmp_out(a6 - 16'h1);
      rnd = lfsr(rnd);
      cmp_out(rnd[15:0]);
    end
    chk(bseen, 1'b1);
    chk(sseen, 1'b1);
    // clear input: ignored in force-high, wins over a waveform mode
    CLEAR_IN <= 1'b1;
    wb(1'b1, 8'h54, 32'h0000_00d0);
    @(posedge CLK);
    chk(COMP_BLANKING, 1'b1);
    wb(1'b1, 8'h54, 32'h0000_00e0);
    @(posedge CLK);
    chk(COMP_BLANKING, 1'b0);
    CLEAR_IN <= 1'b0;
    // mid-run reset: registers and active values back to zero
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    {a5, a6} = 32'h0;
    wb(1'b0, 8'h54, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h64, 32'h0);
    chk(q, {a6, a5});
    chk(COMP_BLANKING, 1'b0);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
